// File: logic/qvfs_consts.vh
// Contract
// - A falling valley comparator marks one detected valley.
// - Time-out pulse after sense stays below valley threshold for 6.5 us.
// - Time-out pulses and valleys merge into one valley clock.
// - Short timer runs continuously, cleared only when sense exceeds short threshold.
// - Short timer at 90 ms declares fault; latch off or pause 4 s.
// - Full load: pulse on first valley clock at low line, second at high.
// - Thermal foldback waits a larger, power-dependent valley count.
// - Low line only after below-threshold report persists beyond 25 ms blanking.
// - High line taken immediately when above-threshold report appears.
// - Dimming reference zero below zero level, full above full, linear between.
// - Gate drive inhibited while dimming input is below zero level.
// - Unconnected dimming input reads as full current through internal pull-up.
// - Current-limit trip after limit blanking ends the gate pulse at once.
// - Four consecutive periods above 150% limit declare winding-short fault.
// - Short blanking is much shorter than limit blanking.
// - Auto-recovery pauses 4 s before restart; latching variants stay off.
// - Supply overvoltage stops pulses and enters auto-recovery in every variant.
// - Shutdown overvoltage latches off or auto-recovers per variant.
// - Drive-latch state high throughout on-time, gating feedforward offset.
// - Entering fault state discharges compensation node, except undervoltage lockout.
`ifndef QVFS_CONSTS_VH
`define QVFS_CONSTS_VH
`define QVFS_CLK_HZ          10000000
`define QVFS_TIMEOUT_NS      6500
`define QVFS_TIMEOUT_CYC     ((`QVFS_TIMEOUT_NS * (`QVFS_CLK_HZ / 1000000)) / 1000)
`define QVFS_SHORT_MS        90
`define QVFS_SHORT_CYC       (`QVFS_SHORT_MS * (`QVFS_CLK_HZ / 1000))
`define QVFS_LL_BLANK_MS     25
`define QVFS_LL_BLANK_CYC    (`QVFS_LL_BLANK_MS * (`QVFS_CLK_HZ / 1000))
`define QVFS_RECOVER_S       4
`define QVFS_RECOVER_CYC     (`QVFS_RECOVER_S * `QVFS_CLK_HZ)
`define QVFS_LIMIT_LEB_NS    300
`define QVFS_LIMIT_LEB_CYC   ((`QVFS_LIMIT_LEB_NS * (`QVFS_CLK_HZ / 1000000) + 999) / 1000)
`define QVFS_SHORT_LEB_NS    100
`define QVFS_SHORT_LEB_CYC   ((`QVFS_SHORT_LEB_NS * (`QVFS_CLK_HZ / 1000000) + 999) / 1000)
`define QVFS_WSHORT_COUNT    3'h4
`define QVFS_VALLEY_LL       4'h1
`define QVFS_VALLEY_HL       4'h2
`define QVFS_DIM_W           8
`endif

// File: logic/qvfs_core.v
`timescale 1ns/1ps
`default_nettype none
`include "qvfs_consts.vh"
module qvfs_core #(
  parameter SHORT_CYC     = `QVFS_SHORT_CYC,
  parameter LL_BLANK_CYC  = `QVFS_LL_BLANK_CYC,
  parameter RECOVER_CYC   = `QVFS_RECOVER_CYC,
  parameter TIMEOUT_CYC   = `QVFS_TIMEOUT_CYC,
  parameter LIMIT_LEB_CYC = `QVFS_LIMIT_LEB_CYC,
  parameter SHORT_LEB_CYC = `QVFS_SHORT_LEB_CYC,
  parameter DIM_W         = `QVFS_DIM_W
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             reset_n,
  // Comparator inputs, asynchronous.
  input  wire             valleyBelow,
  input  wire             auxAboveShort,
  input  wire             lineBelowLow,
  input  wire             lineAboveHigh,
  input  wire             dimBelowZero,
  input  wire             dimAboveFull,
  input  wire             currentLimitTrip,
  input  wire             windingShortTrip,
  input  wire             supplyOvervoltage,
  input  wire             shutdownOvervoltage,
  input  wire             undervoltageLockout,
  // Configuration.
  input  wire             autoRecoverSel,
  input  wire             foldbackActive,
  input  wire [3:0]       foldbackValleys,
  input  wire [DIM_W-1:0] dimLevel,
  // Outputs.
  output reg              gateDrive,
  output reg              driveLatch,
  output reg              compDischarge,
  output reg              lowLine,
  output reg              faultLatched,
  output reg              faultRecovering,
  output reg              auxShortFault,
  output reg              windingShortFault,
  output reg  [DIM_W-1:0] scaledCurrentRef
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_ON     = 2'h1;
  localparam ST_LATCH  = 2'h2;
  localparam ST_PAUSE  = 2'h3;
  localparam [31:0] TO_LIM   = TIMEOUT_CYC;
  localparam [31:0] LLEB_LIM = LIMIT_LEB_CYC;
  localparam [31:0] SLEB_LIM = SHORT_LEB_CYC;

  wire [10:0] syncAll;
  wire        sValley;
  wire        sAuxHi;
  wire        sLineLo;
  wire        sLineHi;
  wire        sDimLo;
  wire        sDimHi;
  wire        sIlim;
  wire        sWsc;
  wire        sVccOv;
  wire        sSdOv;
  wire        sUvlo;
  wire        shortExpired;
  wire        llExpired;
  wire        recoverDone;

  qvfs_sync #(
    .WIDTH (11)
  ) uSync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({valleyBelow, auxAboveShort, lineBelowLow, lineAboveHigh, dimBelowZero,
               dimAboveFull, currentLimitTrip, windingShortTrip, supplyOvervoltage,
               shutdownOvervoltage, undervoltageLockout}),
    .syncOut (syncAll)
  );
  assign sValley = syncAll[10];
  assign sAuxHi  = syncAll[9];
  assign sLineLo = syncAll[8];
  assign sLineHi = syncAll[7];
  assign sDimLo  = syncAll[6];
  assign sDimHi  = syncAll[5];
  assign sIlim   = syncAll[4];
  assign sWsc    = syncAll[3];
  assign sVccOv  = syncAll[2];
  assign sSdOv   = syncAll[1];
  assign sUvlo   = syncAll[0];

  reg  [1:0]  state_r;
  reg         valleyPrev_r;
  reg  [31:0] belowCnt_r;
  reg  [31:0] onCnt_r;
  reg  [3:0]  clkCnt_r;
  reg  [2:0]  wscCnt_r;
  reg         wscSeen_r;
  reg  [1:0]  primed_r;
  wire        valleyEdge;
  wire        timeoutPulse;
  wire        valleyClock;
  wire [3:0]  valleyTarget;
  wire        majorFault;
  wire        latchFault;
  wire        pausing;
  wire        wscHit;
  wire        pauseEnd;

  // A valley is the falling of the sense below the valley threshold.
  assign valleyEdge = sValley & ~valleyPrev_r;
  // Time-out pulse each time the sense stays low for the time-out interval.
  assign timeoutPulse = sValley & (belowCnt_r == TO_LIM - 32'h1);
  assign valleyClock  = valleyEdge | timeoutPulse;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      valleyPrev_r <= 1'b0;
      belowCnt_r   <= 32'h0;
    end else begin
      valleyPrev_r <= sValley;
      if (!sValley || timeoutPulse) begin
        belowCnt_r <= 32'h0;
      end else begin
        belowCnt_r <= belowCnt_r + 32'h1;
      end
    end
  end

  // Short-detection timer runs always and clears only above the short threshold.
  qvfs_timer #(
    .WIDTH (32),
    .LIMIT (SHORT_CYC)
  ) uShortTimer (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (sAuxHi),
    .run     (1'b1),
    .expired (shortExpired)
  );

  // Low-line blanking timer: restarts whenever the below report drops.
  qvfs_timer #(
    .WIDTH (32),
    .LIMIT (LL_BLANK_CYC)
  ) uLineTimer (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (~sLineLo),
    .run     (1'b1),
    .expired (llExpired)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowLine <= 1'b0;
    end else if (sLineHi) begin
      lowLine <= 1'b0;
    end else if (llExpired) begin
      lowLine <= 1'b1;
    end
  end

  // Recovery pause timer, cleared outside the pause state.
  assign pausing = (state_r == ST_PAUSE);
  qvfs_timer #(
    .WIDTH (32),
    .LIMIT (RECOVER_CYC)
  ) uRecoverTimer (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (~pausing),
    .run     (1'b1),
    .expired (recoverDone)
  );

  assign valleyTarget = foldbackActive ? foldbackValleys :
                        (lowLine ? `QVFS_VALLEY_LL : `QVFS_VALLEY_HL);
  assign wscHit     = (wscCnt_r == `QVFS_WSHORT_COUNT);
  assign pauseEnd   = pausing & recoverDone;
  assign latchFault = ~autoRecoverSel &
                      (shortExpired | windingShortFault | wscHit | sSdOv);
  assign majorFault = shortExpired | sVccOv | sSdOv | windingShortFault |
                      wscHit;

  // Gate sequencing and fault state machine.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r           <= ST_IDLE;
      gateDrive         <= 1'b0;
      driveLatch        <= 1'b0;
      clkCnt_r          <= 4'h0;
      onCnt_r           <= 32'h0;
      wscCnt_r          <= 3'h0;
      wscSeen_r         <= 1'b0;
      compDischarge     <= 1'b0;
      faultLatched      <= 1'b0;
      faultRecovering   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          gateDrive  <= 1'b0;
          driveLatch <= 1'b0;
          if (majorFault) begin
            // Latching faults hold off; supply overvoltage always recovers.
            state_r         <= (latchFault && !sVccOv) ? ST_LATCH : ST_PAUSE;
            faultLatched    <= latchFault & ~sVccOv;
            faultRecovering <= ~(latchFault & ~sVccOv);
            compDischarge   <= ~sUvlo;
            clkCnt_r        <= 4'h0;
            wscCnt_r        <= 3'h0;
          end else if (sDimLo) begin
            clkCnt_r <= 4'h0;
          end else if (valleyClock) begin
            if (clkCnt_r + 4'h1 >= valleyTarget) begin
              clkCnt_r   <= 4'h0;
              state_r    <= ST_ON;
              gateDrive  <= 1'b1;
              driveLatch <= 1'b1;
              onCnt_r    <= 32'h0;
              wscSeen_r  <= 1'b0;
            end else begin
              clkCnt_r <= clkCnt_r + 4'h1;
            end
          end
        end
        ST_ON: begin
          onCnt_r <= onCnt_r + 32'h1;
          if (sWsc && (onCnt_r >= SLEB_LIM)) begin
            wscSeen_r <= 1'b1;
          end
          if (majorFault || sDimLo || (sIlim && (onCnt_r >= LLEB_LIM))) begin
            state_r    <= ST_IDLE;
            gateDrive  <= 1'b0;
            driveLatch <= 1'b0;
            if (wscSeen_r || (sWsc && (onCnt_r >= SLEB_LIM))) begin
              wscCnt_r <= (wscCnt_r == `QVFS_WSHORT_COUNT) ? wscCnt_r : wscCnt_r + 3'h1;
            end else begin
              wscCnt_r <= 3'h0;
            end
          end
        end
        ST_LATCH: begin
          gateDrive  <= 1'b0;
          driveLatch <= 1'b0;
        end
        ST_PAUSE: begin
          gateDrive  <= 1'b0;
          driveLatch <= 1'b0;
          if (recoverDone) begin
            state_r           <= ST_IDLE;
            faultRecovering   <= 1'b0;
            compDischarge     <= 1'b0;
            wscCnt_r          <= 3'h0;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Sticky fault flags; a fault event in the cycle the pause ends wins over the clear.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auxShortFault     <= 1'b0;
      windingShortFault <= 1'b0;
    end else begin
      if (shortExpired) begin
        auxShortFault <= 1'b1;
      end else if (pauseEnd) begin
        auxShortFault <= 1'b0;
      end
      if (wscHit) begin
        windingShortFault <= 1'b1;
      end else if (pauseEnd) begin
        windingShortFault <= 1'b0;
      end
    end
  end

  // Dimming reference: full until the synchroniser has filled, then zero, full or linear.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      primed_r         <= 2'h0;
      scaledCurrentRef <= {DIM_W{1'b1}};
    end else begin
      primed_r <= {primed_r[0], 1'b1};
      if (!primed_r[1]) begin
        scaledCurrentRef <= {DIM_W{1'b1}};
      end else if (sDimLo) begin
        scaledCurrentRef <= {DIM_W{1'b0}};
      end else if (sDimHi) begin
        scaledCurrentRef <= {DIM_W{1'b1}};
      end else begin
        scaledCurrentRef <= dimLevel;
      end
    end
  end
endmodule // qvfs_core
`default_nettype wire

// File: logic/qvfs_sync.v
`timescale 1ns/1ps
`default_nettype none
module qvfs_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             clk,
  input  wire             reset_n,
  // Data.
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] meta_r;

  // Two-flop synchroniser for comparator outputs.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r  <= {WIDTH{1'b0}};
      syncOut <= {WIDTH{1'b0}};
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule // qvfs_sync
`default_nettype wire

// File: logic/qvfs_timer.v
`timescale 1ns/1ps
`default_nettype none
module qvfs_timer #(
  parameter WIDTH = 32,
  parameter LIMIT = 1
) (
  // Clock and reset.
  input  wire clk,
  input  wire reset_n,
  // Control.
  input  wire clear,
  input  wire run,
  // Status: level high once the count reached its limit.
  output reg  expired
);
  localparam [WIDTH-1:0] LIM = LIMIT;
  reg [WIDTH-1:0] count_r;

  // Counts clock cycles while run; holds at limit.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (clear) begin
      count_r <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else if (run && (count_r != LIM)) begin
      count_r <= count_r + 1'b1;
      expired <= (count_r + 1'b1) == LIM;
    end
  end
endmodule // qvfs_timer
`default_nettype wire

// File: testbench/qvfs_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module qvfs_core_asserts (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       reset_n,
  // Watched inputs.
  input wire logic       dimBelowZero,
  input wire logic       dimAboveFull,
  input wire logic       lineAboveHigh,
  input wire logic       currentLimitTrip,
  input wire logic       autoRecoverSel,
  // Watched outputs.
  input wire logic       gateDrive,
  input wire logic       driveLatch,
  input wire logic       lowLine,
  input wire logic       faultLatched,
  input wire logic       faultRecovering,
  input wire logic [7:0] scaledCurrentRef
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_latch_follow: assert property (driveLatch == gateDrive)
    else $error("drive latch differs from gate");
  chk_dim_inhibit: assert property (dimBelowZero [*4] |-> !gateDrive)
    else $error("gate on while dimmed off");
  chk_ref_zero: assert property (dimBelowZero [*4] |-> scaledCurrentRef == 8'h00)
    else $error("reference not zero");
  chk_ref_full: assert property ((!dimBelowZero && dimAboveFull) [*4] |-> scaledCurrentRef == 8'hFF)
    else $error("reference not full");
  chk_limit_ends: assert property ($rose(currentLimitTrip) && gateDrive |-> ##[1:6] !gateDrive)
    else $error("limit trip did not end pulse");
  chk_fault_quiet: assert property ((faultLatched || faultRecovering) |-> !gateDrive)
    else $error("gate on in fault state");
  chk_latch_sticky: assert property (faultLatched |=> faultLatched)
    else $error("latched fault cleared");
  chk_latch_variant: assert property ($rose(faultLatched) |-> !autoRecoverSel)
    else $error("latch in recovery variant");
  chk_high_line: assert property (lineAboveHigh [*4] |-> !lowLine)
    else $error("low line kept at high line");
  cover property ($rose(faultLatched));
  cover property ($rose(faultRecovering));
  cover property ($rose(lowLine));
endmodule // qvfs_core_asserts
`default_nettype wire

// File: testbench/qvfs_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module qvfs_stage_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset_n,
  // Gate and commanded faults.
  input  wire logic gateDrive,
  input  wire logic windShort,
  input  wire logic auxDead,
  // Comparator decisions.
  output var  logic currentLimitTrip,
  output var  logic windingShortTrip,
  output var  logic auxAboveShort,
  output var  logic valleyBelow
);
  logic [5:0] cnt_r;
  logic       gPrev_r;
  logic       steady;
  assign steady = (gateDrive == gPrev_r);
  // Current ramps in the on-time; off-time demagnetises, then rings.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 6'h00;
      gPrev_r <= 1'b0;
      currentLimitTrip <= 1'b0;
      windingShortTrip <= 1'b0;
      auxAboveShort <= 1'b0;
      valleyBelow <= 1'b0;
    end else begin
      gPrev_r <= gateDrive;
      cnt_r <= (gateDrive != gPrev_r) ? 6'h00 : cnt_r + 6'h01;
      currentLimitTrip <= gateDrive && steady && cnt_r >= 6'h06;
      windingShortTrip <= gateDrive && steady && windShort && cnt_r >= 6'h02;
      auxAboveShort <= !gateDrive && !auxDead && cnt_r < 6'h08;
      valleyBelow <= gateDrive || auxDead || (steady && cnt_r >= 6'h08 && cnt_r[2]);
    end
  end
endmodule // qvfs_stage_model
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int RECOV = 100;
  logic clk = 1'b0, reset_n = 1'b0, autoRecoverSel = 1'b0;
  logic lineBelowLow = 1'b0, lineAboveHigh = 1'b1, dimBelowZero = 1'b0, dimAboveFull = 1'b1;
  logic supplyOvervoltage = 1'b0, shutdownOvervoltage = 1'b0, undervoltageLockout = 1'b0;
  logic foldbackActive = 1'b0, windShort = 1'b0, auxDead = 1'b0, vPrev = 1'b0;
  logic [3:0] foldbackValleys = 4'h3, vCnt = 4'h0, gap = 4'h0;
  logic [7:0] dimLevel = 8'h00, scaledCurrentRef;
  logic valleyBelow, auxAboveShort, currentLimitTrip, windingShortTrip, gateDrive, driveLatch;
  logic compDischarge, lowLine, faultLatched, faultRecovering, auxShortFault, windingShortFault;
  int num_errors = 0, cmp_count = 0, n, hits;
  always #50 clk = ~clk;
  // Valley edges seen in each off-time.
  always @(posedge clk) begin
    vPrev <= valleyBelow;
    if (gateDrive === 1'b1) begin
      if (vCnt != 4'h0) gap <= vCnt;
      vCnt <= 4'h0;
    end else if (valleyBelow === 1'b1 && vPrev === 1'b0) vCnt <= vCnt + 4'h1;
  end
  qvfs_stage_model i_stage (.clk(clk), .reset_n(reset_n), .gateDrive(gateDrive),
    .windShort(windShort), .auxDead(auxDead), .currentLimitTrip(currentLimitTrip),
    .windingShortTrip(windingShortTrip), .auxAboveShort(auxAboveShort), .valleyBelow(valleyBelow));
  qvfs_core #(.SHORT_CYC(400), .LL_BLANK_CYC(30), .RECOVER_CYC(RECOV), .TIMEOUT_CYC(10)) i_dut (
    .clk(clk), .reset_n(reset_n), .valleyBelow(valleyBelow), .auxAboveShort(auxAboveShort),
    .lineBelowLow(lineBelowLow), .lineAboveHigh(lineAboveHigh), .dimBelowZero(dimBelowZero),
    .dimAboveFull(dimAboveFull), .currentLimitTrip(currentLimitTrip),
    .windingShortTrip(windingShortTrip), .supplyOvervoltage(supplyOvervoltage),
    .shutdownOvervoltage(shutdownOvervoltage), .undervoltageLockout(undervoltageLockout),
    .autoRecoverSel(autoRecoverSel), .foldbackActive(foldbackActive),
    .foldbackValleys(foldbackValleys), .dimLevel(dimLevel), .gateDrive(gateDrive),
    .driveLatch(driveLatch), .compDischarge(compDischarge), .lowLine(lowLine),
    .faultLatched(faultLatched), .faultRecovering(faultRecovering),
    .auxShortFault(auxShortFault), .windingShortFault(windingShortFault),
    .scaledCurrentRef(scaledCurrentRef));
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = gateDrive;
      1: pick = faultLatched;
      2: pick = faultRecovering;
      default: pick = lowLine;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        num_errors++;
        $display("MISMATCH wait %0d expected %b seen timeout", s, v);
        complete_run;
      end
    end
  endtask
  task automatic do_reset(input logic sel);
    reset_n = 1'b0;
    autoRecoverSel = sel;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
  endtask
  task automatic t_line;
    lineAboveHigh = 1'b0;
    lineBelowLow = 1'b1;
    repeat (20) @(negedge clk);
    cmp("lowLine early", 8'h00, lowLine);
    wait_for(3, 1'b1, 20);
    repeat (80) @(negedge clk);
    cmp("valleys low line", 8'h01, {4'h0, gap});
    lineBelowLow = 1'b0;
    lineAboveHigh = 1'b1;
    repeat (4) @(negedge clk);
    cmp("lowLine", 8'h00, lowLine);
    repeat (100) @(negedge clk);
    cmp("valleys high line", 8'h02, {4'h0, gap});
    foldbackActive = 1'b1;
    repeat (120) @(negedge clk);
    cmp("valleys foldback", 8'h03, {4'h0, gap});
    foldbackActive = 1'b0;
  endtask
  task automatic t_dim;
    dimBelowZero = 1'b1;
    dimAboveFull = 1'b0;
    hits = 0;
    repeat (4) @(negedge clk);
    repeat (40) begin
      @(negedge clk);
      if (gateDrive !== 1'b0) hits++;
    end
    cmp("gate dimmed", 8'h00, 8'(hits));
    cmp("ref zero", 8'h00, scaledCurrentRef);
    dimBelowZero = 1'b0;
    dimLevel = 8'h5A;
    repeat (4) @(negedge clk);
    cmp("ref linear", 8'h5A, scaledCurrentRef);
    dimAboveFull = 1'b1;
    repeat (4) @(negedge clk);
    cmp("ref full", 8'hFF, scaledCurrentRef);
    wait_for(0, 1'b1, 80);
  endtask
  task automatic t_aux;
    auxDead = 1'b1;
    repeat (2) begin
      wait_for(0, 1'b0, 20);
      wait_for(0, 1'b1, 40);
    end
    wait_for(2, 1'b1, 500);
    cmp("auxShortFault", 8'h01, auxShortFault);
    cmp("faultLatched", 8'h00, faultLatched);
    cmp("compDischarge", 8'h01, compDischarge);
    auxDead = 1'b0;
    wait_for(2, 1'b0, RECOV + 20);
    cmp("pause long", 8'h01, {7'h00, n >= RECOV - 5});
    cmp("flag cleared", 8'h00, auxShortFault);
  endtask
  task automatic t_wind;
    windShort = 1'b1;
    wait_for(1, 1'b1, 400);
    windShort = 1'b0;
    cmp("windingShortFault", 8'h01, windingShortFault);
    cmp("faultRecovering", 8'h00, faultRecovering);
    repeat (RECOV + 50) @(negedge clk);
    cmp("latch held", 8'h01, faultLatched);
    do_reset(1'b0);
    cmp("latch reset", 8'h00, faultLatched);
  endtask
  task automatic t_ovp;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      shutdownOvervoltage = 1'b1;
      wait_for(s == 0 ? 1 : 2, 1'b1, 80);
      shutdownOvervoltage = 1'b0;
      cmp("shutdown latch", {7'h00, !s[0]}, faultLatched);
      cmp("shutdown pause", {7'h00, s[0]}, faultRecovering);
    end
    do_reset(1'b0);
    undervoltageLockout = 1'b1;
    supplyOvervoltage = 1'b1;
    wait_for(2, 1'b1, 80);
    cmp("supply latch", 8'h00, faultLatched);
    cmp("no discharge", 8'h00, compDischarge);
  endtask
  initial begin
    do_reset(1'b1);
    cmp("ref at reset", 8'hFF, scaledCurrentRef);
    t_line;
    t_dim;
    t_aux;
    do_reset(1'b0);
    t_wind;
    t_ovp;
    complete_run;
  end
endmodule // tb
bind qvfs_core qvfs_core_asserts i_chk (.clk(clk), .reset_n(reset_n),
  .dimBelowZero(dimBelowZero), .dimAboveFull(dimAboveFull), .lineAboveHigh(lineAboveHigh),
  .currentLimitTrip(currentLimitTrip), .autoRecoverSel(autoRecoverSel), .gateDrive(gateDrive),
  .driveLatch(driveLatch), .lowLine(lowLine), .faultLatched(faultLatched),
  .faultRecovering(faultRecovering), .scaledCurrentRef(scaledCurrentRef));
`default_nettype wire
